//--- hdl/dma_trig_pkg.sv
// constants and types shared by the dma trigger front end and its latch
// assumes one 200 mhz clock domain and an asynchronous active-low reset
package dma_trig_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // structure
  localparam int NUM_CH = 6;
  localparam int NUM_SRC = 18;
  localparam int SEL_W = 5;
  localparam int CH_W = 3;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BURST_W = 8;
  localparam int PHASE_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // source select codes, code 0 is software force only
  localparam logic [4:0] SRC_SOFTWARE = 5'h00;
  localparam logic [4:0] SRC_EXT_LINE1 = 5'h01;
  localparam logic [4:0] SRC_EXT_LINE7 = 5'h07;
  localparam logic [4:0] SRC_EXT_LINE13 = 5'h08;
  localparam logic [4:0] SRC_TIMER0 = 5'h09;
  localparam logic [4:0] SRC_TIMER1 = 5'h0a;
  localparam logic [4:0] SRC_TIMER2 = 5'h0b;
  localparam logic [4:0] SRC_SERIAL_A_TX = 5'h0c;
  localparam logic [4:0] SRC_SERIAL_A_RX = 5'h0d;
  localparam logic [4:0] serial_b_transmit_event = 5'h0e;
  localparam logic [4:0] serial_b_receive_event = 5'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // timing in clock cycles
  localparam logic [2:0] WORD_CYCLES = 3'h4;
  localparam logic [2:0] SERIAL_RD_CYCLES = 3'h5;
  localparam int BURST_GAP_CYCLES = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic PEND_RST = 1'b0;
  localparam logic OVF_RST = 1'b0;
  localparam logic [2:0] LAST_CH_RST = 3'h5;
  localparam logic [21:0] ADDR_RST = 22'h000000;
  localparam logic [31:0] DATA_RST = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_GAP = 4'b0010,
    SEQ_WORD = 4'b0100,
    SEQ_END = 4'b1000
  } seq_state_t;

endpackage

//--- hdl/trigger_latch.sv
// per-channel trigger latch: pending flag, overflow flag, source clear pulse
// assumes the source drops its event within one cycle of the clear pulse
`timescale 1ns/1ps
`default_nettype none

module trigger_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic evt,
  input wire logic input_en,
  input wire logic force_trig,
  input wire logic sw_clear,
  input wire logic burst_start,
  input wire logic in_burst,
  input wire logic ovf_clear,
  output logic pending,
  output logic overflow,
  output logic src_ack
);

  logic pending_ff;
  logic overflow_ff;
  logic ack_hold_ff;
  logic accept;
  logic set_trig;

  ////////////////////////////////////////////////////////////////////////////
  // event acceptance, the hold cycle stops one event counting twice
  assign accept = evt & input_en & ~ack_hold_ff;
  assign set_trig = accept | force_trig;
  assign src_ack = accept;

  // hold after a clear pulse so the dropping event is not seen again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_hold_ff <= 1'b0;
    end else begin
      ack_hold_ff <= accept;
    end
  end

  // pending flag: a new trigger beats any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_ff <= dma_trig_pkg::PEND_RST;
    end else if (set_trig) begin
      pending_ff <= 1'b1;
    end else if (burst_start || sw_clear) begin
      pending_ff <= 1'b0;
    end
  end

  // overflow: trigger while one is pending and a burst runs, sticky
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_ff <= dma_trig_pkg::OVF_RST;
    end else if (set_trig && pending_ff && in_burst) begin
      overflow_ff <= 1'b1;
    end else if (ovf_clear) begin
      overflow_ff <= 1'b0;
    end
  end

  assign pending = pending_ff;
  assign overflow = overflow_ff;

endmodule // trigger_latch

`default_nettype wire

//--- hdl/dma_trigger_front.sv
// six-channel dma trigger front end with burst sequencer and transfer bus
// assumes synchronous inputs, a one-cycle read latency on bus_rdata and one
// extra stall cycle when the source is a serial receive data register
//
// Functional notes
// - six channels each select among eighteen sources
// - select field routes source to channel latch
// - trigger sets pending; serviced when enabled and running
// - accepted event returns a clear pulse to source
// - force bit sets pending regardless of select
// - clear bit drops pending regardless of select
// - pending holds until burst starts, then clears
// - new trigger never interrupts the running burst
// - second trigger while pending during a burst sets overflow flag
// - set beats clear in the same cycle
// - sources: software, lines 1-7,13, timers, serial
// - per-channel interrupt on burst start or end
// - channel 1 alone may take higher priority
// - 22-bit address, separate 32-bit read/write buses
// - 16 or 32-bit words, serial ports 16-bit
// - four cycles per word, five for serial reads
// - no internal periodic start, only latched triggers
// - bus reaches memory zones, ram blocks, serial registers
`timescale 1ns/1ps
`default_nettype none

module dma_trigger_front #(
  parameter int NUM_CH = dma_trig_pkg::NUM_CH,
  parameter int NUM_SRC = dma_trig_pkg::NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] periph_evt,
  output logic [NUM_SRC-1:0] periph_clr,
  input wire logic [NUM_CH*dma_trig_pkg::SEL_W-1:0] trigger_source_select,
  input wire logic [NUM_CH-1:0] trigger_input_enable,
  input wire logic [NUM_CH-1:0] channel_run_status,
  input wire logic [NUM_CH-1:0] trigger_force_bit,
  input wire logic [NUM_CH-1:0] trigger_clear_bit,
  input wire logic [NUM_CH-1:0] overflow_clear,
  input wire logic ch1_high_priority,
  input wire logic [NUM_CH*dma_trig_pkg::BURST_W-1:0] burst_words_m1,
  input wire logic [NUM_CH-1:0] word_size_32,
  input wire logic [NUM_CH-1:0] src_is_serial,
  input wire logic [NUM_CH-1:0] dst_is_serial,
  input wire logic [NUM_CH*dma_trig_pkg::ADDR_W-1:0] src_base,
  input wire logic [NUM_CH*dma_trig_pkg::ADDR_W-1:0] dst_base,
  input wire logic [NUM_CH-1:0] irq_at_end,
  output logic [NUM_CH-1:0] trigger_pending_flag,
  output logic [NUM_CH-1:0] trigger_overflow_flag,
  output logic [NUM_CH-1:0] channel_irq,
  output logic busy,
  output logic [dma_trig_pkg::CH_W-1:0] active_channel,
  output logic [dma_trig_pkg::ADDR_W-1:0] bus_addr,
  output logic bus_rd_en,
  output logic bus_wr_en,
  output logic bus_wide,
  input wire logic [dma_trig_pkg::DATA_W-1:0] bus_rdata,
  output logic [dma_trig_pkg::DATA_W-1:0] bus_wdata
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (NUM_CH < 2 || NUM_CH > (1 << dma_trig_pkg::CH_W)) begin : g_bad_ch
    $error("channel count not served by the arbiter");
  end
  if (NUM_SRC < 2 || NUM_SRC > (1 << dma_trig_pkg::SEL_W)) begin : g_bad_src
    $error("source count not served by the select field");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  dma_trig_pkg::seq_state_t state_ff;
  dma_trig_pkg::seq_state_t nxt_state;
  logic [dma_trig_pkg::CH_W-1:0] cur_ch_ff;
  logic [dma_trig_pkg::CH_W-1:0] last_ch_ff;
  logic [dma_trig_pkg::CH_W-1:0] pick_ch;
  logic pick_valid;
  logic [dma_trig_pkg::PHASE_W-1:0] phase_ff;
  logic [dma_trig_pkg::BURST_W-1:0] word_idx_ff;
  logic [dma_trig_pkg::ADDR_W-1:0] offset_ff;
  logic [NUM_CH-1:0] sel_evt;
  logic [NUM_CH-1:0] src_ack;
  logic [NUM_CH-1:0] ready;
  logic [NUM_CH-1:0] start_vec;
  logic [NUM_CH-1:0] irq_ff;
  logic [dma_trig_pkg::ADDR_W-1:0] addr_ff;
  logic rd_ff;
  logic wr_ff;
  logic wide_ff;
  logic [dma_trig_pkg::DATA_W-1:0] wdata_ff;
  logic burst_start;
  logic cur_wide;
  logic cur_src_serial;
  logic [dma_trig_pkg::PHASE_W-1:0] word_last;
  logic [dma_trig_pkg::PHASE_W-1:0] cap_phase;
  logic [dma_trig_pkg::BURST_W-1:0] cur_words_m1;
  logic [dma_trig_pkg::ADDR_W-1:0] cur_src_base;
  logic [dma_trig_pkg::ADDR_W-1:0] cur_dst_base;
  logic [dma_trig_pkg::ADDR_W-1:0] step;
  logic word_done;
  logic burst_done;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel source select and trigger latch
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [dma_trig_pkg::SEL_W-1:0] sel;

    assign sel = trigger_source_select[c*dma_trig_pkg::SEL_W +: dma_trig_pkg::SEL_W];

    // code 0 and codes past the last source route no event
    always_comb begin
      sel_evt[c] = 1'b0;
      if (sel != dma_trig_pkg::SRC_SOFTWARE && int'(sel) < NUM_SRC) begin
        sel_evt[c] = periph_evt[sel];
      end
    end

    // service only with input enable and run status both set
    assign ready[c] = trigger_pending_flag[c] & trigger_input_enable[c]
                      & channel_run_status[c];

    assign start_vec[c] = burst_start && (int'(pick_ch) == c);

    trigger_latch u_latch (
      .clk(clk),
      .rst_n(rst_n),
      .evt(sel_evt[c]),
      .input_en(trigger_input_enable[c]),
      .force_trig(trigger_force_bit[c]),
      .sw_clear(trigger_clear_bit[c]),
      .burst_start(start_vec[c]),
      .in_burst(busy),
      .ovf_clear(overflow_clear[c]),
      .pending(trigger_pending_flag[c]),
      .overflow(trigger_overflow_flag[c]),
      .src_ack(src_ack[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // clear pulses back to every source that a channel accepted from
  always_comb begin
    periph_clr = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (src_ack[c]) begin
        periph_clr[trigger_source_select[c*dma_trig_pkg::SEL_W +: dma_trig_pkg::SEL_W]]
          = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: round robin after the last served channel, channel 1 first
  // when its high priority mode is on; only evaluated between bursts
  always_comb begin
    int idx;
    idx = 0;
    pick_ch = '0;
    pick_valid = 1'b0;
    if (ch1_high_priority && ready[0]) begin
      pick_valid = 1'b1;
    end else begin
      for (int k = NUM_CH; k >= 1; k--) begin
        idx = (int'(last_ch_ff) + k) % NUM_CH;
        if (ready[idx]) begin
          pick_ch = dma_trig_pkg::CH_W'(idx);
          pick_valid = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current channel configuration
  assign cur_words_m1 = burst_words_m1[cur_ch_ff*dma_trig_pkg::BURST_W +: dma_trig_pkg::BURST_W];
  assign cur_src_base = src_base[cur_ch_ff*dma_trig_pkg::ADDR_W +: dma_trig_pkg::ADDR_W];
  assign cur_dst_base = dst_base[cur_ch_ff*dma_trig_pkg::ADDR_W +: dma_trig_pkg::ADDR_W];
  assign cur_src_serial = src_is_serial[cur_ch_ff];
  // serial data registers only take 16-bit accesses
  assign cur_wide = word_size_32[cur_ch_ff] & ~src_is_serial[cur_ch_ff]
                    & ~dst_is_serial[cur_ch_ff];
  assign step = cur_wide ? 22'h000002 : 22'h000001;
  // serial reads stall the bus one cycle
  assign word_last = cur_src_serial ? (dma_trig_pkg::SERIAL_RD_CYCLES - 3'h1)
                                    : (dma_trig_pkg::WORD_CYCLES - 3'h1);
  assign cap_phase = word_last - 3'h1;
  assign word_done = (state_ff == dma_trig_pkg::SEQ_WORD) && (phase_ff == word_last);
  assign burst_done = word_done && (word_idx_ff == cur_words_m1);
  // burst starts only from a latched trigger
  assign burst_start = (state_ff == dma_trig_pkg::SEQ_IDLE) && pick_valid;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dma_trig_pkg::SEQ_IDLE: begin
        if (pick_valid) begin
          nxt_state = dma_trig_pkg::SEQ_GAP;
        end
      end
      dma_trig_pkg::SEQ_GAP: begin
        nxt_state = dma_trig_pkg::SEQ_WORD;
      end
      dma_trig_pkg::SEQ_WORD: begin
        if (burst_done) begin
          nxt_state = dma_trig_pkg::SEQ_END;
        end
      end
      dma_trig_pkg::SEQ_END: begin
        nxt_state = dma_trig_pkg::SEQ_IDLE;
      end
      default: begin
        nxt_state = dma_trig_pkg::SEQ_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= dma_trig_pkg::SEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // channel capture at burst start, remembered for round robin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ch_ff <= '0;
      last_ch_ff <= dma_trig_pkg::LAST_CH_RST;
    end else if (burst_start) begin
      cur_ch_ff <= pick_ch;
      last_ch_ff <= pick_ch;
    end
  end

  // phase and word counters, address offset within the burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= '0;
      word_idx_ff <= '0;
      offset_ff <= dma_trig_pkg::ADDR_RST;
    end else if (state_ff != dma_trig_pkg::SEQ_WORD) begin
      phase_ff <= '0;
      word_idx_ff <= '0;
      offset_ff <= dma_trig_pkg::ADDR_RST;
    end else if (word_done) begin
      phase_ff <= '0;
      word_idx_ff <= word_idx_ff + 8'h01;
      offset_ff <= offset_ff + step;
    end else begin
      phase_ff <= phase_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer bus: read request in phase 1, write in the cycle after capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= dma_trig_pkg::ADDR_RST;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      wide_ff <= 1'b0;
    end else begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      if (state_ff == dma_trig_pkg::SEQ_WORD && phase_ff == '0) begin
        addr_ff <= cur_src_base + offset_ff;
        rd_ff <= 1'b1;
        wide_ff <= cur_wide;
      end else if (state_ff == dma_trig_pkg::SEQ_WORD && phase_ff == cap_phase) begin
        addr_ff <= cur_dst_base + offset_ff;
        wr_ff <= 1'b1;
        wide_ff <= cur_wide;
      end
    end
  end

  // write data captured from the read bus, upper half zero for 16-bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_ff <= dma_trig_pkg::DATA_RST;
    end else if (state_ff == dma_trig_pkg::SEQ_WORD && phase_ff == cap_phase) begin
      wdata_ff <= cur_wide ? bus_rdata
                           : {{dma_trig_pkg::HALF_W{1'b0}},
                              bus_rdata[dma_trig_pkg::HALF_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel interrupt pulse at burst start or at burst end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        irq_ff[c] <= (start_vec[c] && !irq_at_end[c])
                     || (burst_done && int'(cur_ch_ff) == c && irq_at_end[c]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign channel_irq = irq_ff;
  assign busy = (state_ff != dma_trig_pkg::SEQ_IDLE);
  assign active_channel = cur_ch_ff;
  assign bus_addr = addr_ff;
  assign bus_rd_en = rd_ff;
  assign bus_wr_en = wr_ff;
  assign bus_wide = wide_ff;
  assign bus_wdata = wdata_ff;

endmodule // dma_trigger_front

`default_nettype wire

//--- dv/dma_trig_chk.sv
// concurrent checks on the ports of the dma trigger front end
// assumes one clock domain and the active-low reset of the design
`timescale 1ns/1ps
`default_nettype none
module dma_trig_chk #(
  parameter int NUM_CH = dma_trig_pkg::NUM_CH,
  parameter int NUM_SRC = dma_trig_pkg::NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] periph_evt,
  input wire logic [NUM_SRC-1:0] periph_clr,
  input wire logic [NUM_CH-1:0] trigger_force_bit,
  input wire logic [NUM_CH-1:0] trigger_clear_bit,
  input wire logic [NUM_CH-1:0] overflow_clear,
  input wire logic [NUM_CH-1:0] src_is_serial,
  input wire logic [NUM_CH-1:0] dst_is_serial,
  input wire logic [NUM_CH-1:0] trigger_pending_flag,
  input wire logic [NUM_CH-1:0] trigger_overflow_flag,
  input wire logic [NUM_CH-1:0] channel_irq,
  input wire logic busy,
  input wire logic [dma_trig_pkg::CH_W-1:0] active_channel,
  input wire logic bus_rd_en,
  input wire logic bus_wr_en,
  input wire logic bus_wide
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // trigger latch flags
  chk_force_sets_pend: assert property (
    (~trigger_pending_flag & $past(trigger_force_bit)) == '0) else $error("force lost");
  chk_clear_drops_pend: assert property (
    $past(periph_evt) == '0 |->
    (trigger_pending_flag & $past(trigger_clear_bit) & ~$past(trigger_force_bit)) == '0)
    else $error("clear ignored");
  chk_pend_holds: assert property (
    ($past(trigger_pending_flag) & ~trigger_pending_flag & ~$past(trigger_clear_bit)) != '0
    |-> $rose(busy)) else $error("pending dropped without burst start");
  chk_ovf_sticky: assert property (
    (~trigger_overflow_flag & $past(trigger_overflow_flag) & ~$past(overflow_clear)) == '0)
    else $error("overflow dropped");
  chk_ovf_in_burst: assert property (
    (trigger_overflow_flag & ~$past(trigger_overflow_flag)) != '0 |-> $past(busy))
    else $error("overflow outside burst");
  chk_clr_to_source: assert property (
    (periph_clr & ~periph_evt) == '0 && !periph_clr[0]) else $error("stray clear pulse");
  chk_accept_pends: assert property (
    periph_clr != '0 |=> trigger_pending_flag != '0) else $error("accept not latched");
  ////////////////////////////////////////
  // burst and bus timing
  chk_burst_gap: assert property (
    $rose(busy) |-> !bus_rd_en [*2] ##1 bus_rd_en) else $error("burst start gap");
  chk_word_spacing: assert property (
    bus_rd_en |=> !bus_rd_en [*3]) else $error("words too close");
  chk_mem_word: assert property (
    bus_rd_en && !src_is_serial[active_channel] |-> ##2 bus_wr_en)
    else $error("write not two after read");
  chk_serial_word: assert property (
    bus_rd_en && src_is_serial[active_channel] |-> !bus_wr_en [*3] ##1 bus_wr_en)
    else $error("serial read stall");
  chk_serial_narrow: assert property (
    bus_rd_en && (src_is_serial[active_channel] || dst_is_serial[active_channel])
    |-> !bus_wide) else $error("wide serial access");
  chk_burst_channel: assert property (
    busy && $past(busy) |-> $stable(active_channel)) else $error("burst interrupted");
  chk_irq_pulse: assert property (
    channel_irq != '0 |=> (channel_irq & $past(channel_irq)) == '0)
    else $error("irq longer than a cycle");
endmodule // dma_trig_chk

bind dma_trigger_front dma_trig_chk #(.NUM_CH(NUM_CH), .NUM_SRC(NUM_SRC)) chk_i (
  .clk, .rst_n, .periph_evt, .periph_clr, .trigger_force_bit, .trigger_clear_bit,
  .overflow_clear, .src_is_serial, .dst_is_serial, .trigger_pending_flag,
  .trigger_overflow_flag, .channel_irq, .busy, .active_channel, .bus_rd_en,
  .bus_wr_en, .bus_wide
);
`default_nettype wire

//--- dv/periph_model.sv
// event sources and memory behind the dma transfer bus
// assumes read data is taken within two cycles of the read strobe
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [17:0] raise,
  input wire logic [17:0] periph_clr,
  output logic [17:0] periph_evt,
  input wire logic bus_rd_en,
  input wire logic [21:0] bus_addr,
  output logic [31:0] bus_rdata
);
  logic [1:0] hold_ff;
  // a source keeps its event up until the clear pulse comes back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) periph_evt <= '0;
    else periph_evt <= (periph_evt & ~periph_clr) | raise;
  end
  // read data valid three cycles, then scrambled every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 2'h0;
      bus_rdata <= 32'h0;
    end else if (bus_rd_en) begin
      hold_ff <= 2'h2;
      bus_rdata <= {10'h0, bus_addr} ^ 32'h5a5aa5a5;
    end else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
    else bus_rdata <= ~bus_rdata;
  end
endmodule // periph_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the dma trigger front end
// partner model supplies events and read data; config bits are ports
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hp = 1'b0;
  logic [17:0] raise = '0;
  logic [29:0] sel = '0;
  logic [5:0] ie = '0, run = '0, frc = '0, clr = '0, oclr = '0;
  logic [5:0] w32 = '0, ss = '0, ds = '0, iae = '0, m, rem;
  logic [47:0] bw = '0;
  logic [131:0] sb = '0, db = '0;
  logic [17:0] evt, pclr;
  logic [5:0] pend, ovf, irq;
  logic busy, rd, wr, wide, rd_wide;
  logic [2:0] ach;
  logic [21:0] addr, rd_addr;
  logic [31:0] rdata, wdata;
  int n_mismatch = 0, compares = 0, seed = 81, i, k, words, irqs, last_ch = 0, off = 0;
  // 200 mhz clock
  always #2.5 clk = ~clk;
  dma_trigger_front uut (
    .clk(clk), .rst_n(rst_n), .periph_evt(evt), .periph_clr(pclr),
    .trigger_source_select(sel), .trigger_input_enable(ie), .channel_run_status(run),
    .trigger_force_bit(frc), .trigger_clear_bit(clr), .overflow_clear(oclr),
    .ch1_high_priority(hp), .burst_words_m1(bw), .word_size_32(w32),
    .src_is_serial(ss), .dst_is_serial(ds), .src_base(sb), .dst_base(db),
    .irq_at_end(iae), .trigger_pending_flag(pend), .trigger_overflow_flag(ovf),
    .channel_irq(irq), .busy(busy), .active_channel(ach), .bus_addr(addr),
    .bus_rd_en(rd), .bus_wr_en(wr), .bus_wide(wide), .bus_rdata(rdata), .bus_wdata(wdata)
  );
  periph_model pm (
    .clk(clk), .rst_n(rst_n), .raise(raise), .periph_clr(pclr), .periph_evt(evt),
    .bus_rd_en(rd), .bus_addr(addr), .bus_rdata(rdata)
  );
  ////////////////////////////////////////
  // comparisons, expectations, waits
  task automatic chk6(string nm, logic [5:0] e, logic [5:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] exp_word(logic [21:0] a, logic w);
    logic [31:0] d;
    d = {10'h0, a} ^ 32'h5a5aa5a5;
    exp_word = w ? d : {16'h0, d[15:0]};
  endfunction
  function automatic int exp_words(logic [5:0] mk, logic [47:0] b);
    exp_words = 0;
    for (int c = 0; c < 6; c++) if (mk[c]) exp_words += b[c*8 +: 8] + 1;
  endfunction
  // next channel served: channel index 0 when its priority mode is on, else round robin
  function automatic int next_pick(logic [5:0] mk, logic h, int last);
    next_pick = last;
    if (h && mk[0]) return 0;
    for (int j = 1; j <= 6; j++) if (mk[(last + j) % 6]) return (last + j) % 6;
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_for(logic want_busy);
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (want_busy ? busy === 1'b1 : busy === 1'b0 && (pend & ie & run) === 6'h00) break;
    end
    if (k == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // follows each word over the transfer bus
  always @(posedge clk) begin
    if (busy !== 1'b1) off <= 0;
    if (rd === 1'b1) begin
      rd_addr <= addr;
      rd_wide <= w32[ach] & ~ss[ach] & ~ds[ach];
      chk6("bus wide", 6'(w32[ach] & ~ss[ach] & ~ds[ach]), 6'(wide));
      chk32("read addr", 32'(22'(sb[ach*22 +: 22] + off)), 32'(addr));
    end
    if (wr === 1'b1) begin
      chk32("write data", exp_word(rd_addr, rd_wide), wdata);
      chk32("write addr", 32'(22'(db[ach*22 +: 22] + off)), 32'(addr));
      off <= off + (rd_wide ? 2 : 1);
      words <= words + 1;
    end
    if (irq !== 6'h00) begin
      chk6("irq channel", 6'h01 << ach, irq);
      irqs <= irqs + 1;
    end
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    words = 0;
    irqs = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk6("pending", 6'h00, pend);
    chk6("overflow", 6'h00, ovf);
    // source codes 1 to 15 each routed to one channel, the rest cleared
    for (i = 1; i < 16; i++) begin
      @(posedge clk);
      sel <= 30'(i) << ((i % 6) * 5);
      ie <= 6'h3f;
      clr <= 6'h3f;
      @(posedge clk);
      clr <= '0;
      raise <= 18'h1 << i;
      @(posedge clk);
      raise <= '0;
      @(posedge clk);
      #1;
      chk6("pending", 6'h01 << (i % 6), pend);
      chk32("event", 32'h0, {14'h0, evt});
    end
    // a disabled input ignores its source
    @(posedge clk);
    clr <= 6'h3f;
    ie <= 6'h3d;
    sel <= 30'h20;
    @(posedge clk);
    clr <= '0;
    raise <= 18'h2;
    repeat (3) @(posedge clk);
    #1;
    chk6("pending", 6'h00, pend);
    chk32("event", 32'h2, {14'h0, evt});
    // forced triggers, then set against clear
    @(posedge clk);
    raise <= '0;
    sel <= '0;
    ie <= 6'h3f;
    frc <= 6'h2a;
    @(posedge clk);
    frc <= 6'h01;
    clr <= 6'h3f;
    #1;
    chk6("pending", 6'h2a, pend);
    @(posedge clk);
    frc <= '0;
    clr <= '0;
    #1;
    chk6("pending", 6'h01, pend);
    chk6("overflow", 6'h00, ovf);
    // retrigger twice during a long burst
    @(posedge clk);
    bw <= 48'h3f;
    run <= 6'h01;
    wait_for(1'b1);
    frc <= 6'h01;
    @(posedge clk);
    frc <= '0;
    @(posedge clk);
    frc <= 6'h01;
    @(posedge clk);
    frc <= '0;
    #1;
    chk6("overflow", 6'h01, ovf);
    wait_for(1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk32("words", 32'd128, words);
    chk32("irqs", 32'd2, irqs);
    chk6("overflow", 6'h01, ovf);
    @(posedge clk);
    oclr <= 6'h01;
    @(posedge clk);
    oclr <= '0;
    #1;
    chk6("overflow", 6'h00, ovf);
    // random bursts over all channels
    for (i = 0; i < 24; i++) begin
      @(posedge clk);
      words = 0;
      irqs = 0;
      m = 6'($random(seed)) | (6'h01 << (i % 6));
      bw <= 48'({$random(seed), $random(seed)}) & 48'h030303030303;
      {w32, ss, ds, iae} <= 24'($random(seed));
      hp <= 1'($random(seed));
      sb <= 132'({5{$random(seed)}});
      db <= 132'({5{$random(seed)}});
      run <= 6'h3f;
      frc <= m;
      @(posedge clk);
      frc <= '0;
      wait_for(1'b1);
      #1;
      chk6("first channel", 6'(next_pick(m, hp, last_ch)), {3'h0, ach});
      rem = m;
      for (int j = 0; j < 6; j++) begin
        if (rem != '0) begin
          last_ch = next_pick(rem, hp, last_ch);
          rem[last_ch] = 1'b0;
        end
      end
      wait_for(1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk32("words", 32'(exp_words(m, bw)), words);
      chk32("irqs", 32'($countones(m)), irqs);
      chk6("pending", 6'h00, pend);
    end
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
